/* frs_regs.v */
// Rate-select, digital input and status byte 0 register logic.
`timescale 1ns/100ps
`default_nettype none
`include "frs_defs.vh"
module frs_regs (
  // Clock and resets
  input wire clock,
  input wire sys_rst,
  input wire soft_rst,
  // Host register port
  input wire [2:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  // Mode and shared state
  input wire [1:0] compat_mode,
  input wire [7:0] digital_output_reg,
  input wire disk_changed,
  input wire shadow_sel,
  input wire shadow_disk_changed,
  // Drive side
  output wire [1:0] data_rate,
  output reg density_select_pin,
  // Result phase status byte 0 sources
  input wire result_load,
  input wire [1:0] termination_code,
  input wire seek_end,
  input wire equipment_check,
  input wire head_addr,
  input wire [1:0] drive_number,
  output reg [7:0] status0
);

  // ****************************************
  // Local sizes
  // ****************************************
  // The software reset input is kept for the port map; nothing here is cleared by it.
  localparam RATE_W = 2;
  localparam DATA_W = 8;
  localparam ST0_W = 8;

  genvar g;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // The shared offset is decoded for both directions, so one function serves both.
  function hits_shared;
    input [2:0] addr;
    begin
      hits_shared = (addr == `FRS_OFS_CFG_DIN);
    end
  endfunction

  // Low density at 250K and 300K; high density at 500K and 1M.
  function low_dens_of;
    input [1:0] rate;
    begin
      case (rate)
        `FRS_RATE_250K: begin
          low_dens_of = 1'b1;
        end
        `FRS_RATE_300K: begin
          low_dens_of = 1'b1;
        end
        `FRS_RATE_500K: begin
          low_dens_of = 1'b0;
        end
        `FRS_RATE_1M: begin
          low_dens_of = 1'b0;
        end
        default: begin
          low_dens_of = 1'b0;
        end
      endcase
    end
  endfunction

  // ****************************************
  // Read layouts
  // ****************************************
  function [7:0] din_second;
    input dsk;
    input [1:0] rate;
    reg [7:0] word;
    begin
      word = 8'h00;
      word[7] = dsk;
      word[6] = 1'b1;
      word[5] = 1'b1;
      word[4] = 1'b1;
      word[3] = 1'b1;
      word[2] = rate[1];
      word[1] = rate[0];
      word[0] = low_dens_of(rate);
      din_second = word;
    end
  endfunction

  function [7:0] din_third;
    input dsk;
    input xfer_en;
    input precomp;
    input [1:0] rate;
    reg [7:0] word;
    begin
      word = 8'h00;
      word[7] = dsk;
      word[6] = 1'b0;
      word[5] = 1'b0;
      word[4] = 1'b0;
      word[3] = xfer_en;
      word[2] = precomp;
      word[1] = rate[1];
      word[0] = rate[0];
      din_third = word;
    end
  endfunction

  // Bits 6..0 of the base layout are undefined and read as zero.
  function [7:0] din_base;
    input dsk;
    reg [7:0] word;
    begin
      word = 8'h00;
      word[7] = dsk;
      din_base = word;
    end
  endfunction

  function [7:0] status_word;
    input [1:0] tc;
    input seek;
    input equip;
    input head;
    input [1:0] drive;
    reg [7:0] word;
    begin
      word = 8'h00;
      word[7] = tc[1];
      word[6] = tc[0];
      word[5] = seek;
      word[4] = equip;
      word[3] = 1'b0;
      word[2] = head;
      word[1] = drive[1];
      word[0] = drive[0];
      status_word = word;
    end
  endfunction

  // ****************************************
  // Host access decode
  // ****************************************
  wire cfg_wr;
  wire din_rd;

  assign cfg_wr = io_wr && hits_shared(io_addr);
  assign din_rd = io_rd && hits_shared(io_addr);

  // ****************************************
  // Mode decode
  // ****************************************
  reg third_mode;

  always @* begin
    case (compat_mode)
      `FRS_MODE_THIRD: begin
        third_mode = 1'b1;
      end
      default: begin
        third_mode = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Configuration control storage
  // ****************************************
  reg [RATE_W-1:0] rate_r;
  reg [RATE_W-1:0] rate_nxt;
  reg precomp_off_r;
  reg precomp_off_nxt;
  wire rate_sel_lo;
  wire rate_sel_hi;
  wire low_density_flag;
  wire [RATE_W-1:0] rate_word;

  // The latest write decides the rate; reserved bits 7..3 are dropped here.
  always @* begin
    rate_nxt = rate_r;
    if (cfg_wr) begin
      rate_nxt = io_wdata[1:0];
    end
  end

  // Outside the third mode bit 2 is reserved, so a write leaves the stored copy alone.
  always @* begin
    precomp_off_nxt = precomp_off_r;
    if (cfg_wr && third_mode) begin
      precomp_off_nxt = io_wdata[`FRS_BIT_PRECOMP];
    end
  end

  // Soft reset is deliberately absent: rate and precomp bits survive it.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rate_r <= `FRS_RATE_RST;
    end else begin
      rate_r <= rate_nxt;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      precomp_off_r <= 1'b0;
    end else begin
      precomp_off_r <= precomp_off_nxt;
    end
  end

  assign data_rate = rate_r;
  assign rate_sel_lo = rate_r[0];
  assign rate_sel_hi = rate_r[1];
  assign rate_word = {rate_sel_hi, rate_sel_lo};
  assign low_density_flag = low_dens_of(rate_r);

  // ****************************************
  // Density select pin
  // ****************************************
  reg density_nxt;

  // Follows the rate one clock later, so outside hardware reset the pin changes only on a clock edge.
  always @* begin
    if (low_density_flag) begin
      density_nxt = 1'b0;
    end else begin
      density_nxt = 1'b1;
    end
  end

  // Only hardware reset presets it; register-issued resets never reach here.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      density_select_pin <= 1'b1;
    end else begin
      density_select_pin <= density_nxt;
    end
  end

  // ****************************************
  // Disk-change and transfer-enable bits
  // ****************************************
  wire dsk_bit;
  wire xfer_en_bit;

  // The shadow copy is taken as written; only the cable level is inverted.
  assign dsk_bit = shadow_sel ? shadow_disk_changed : ~disk_changed;
  assign xfer_en_bit = digital_output_reg[`FRS_BIT_XFER_EN];

  // ****************************************
  // Digital input register read
  // ****************************************
  reg [DATA_W-1:0] din_value;
  reg [DATA_W-1:0] rdata_nxt;
  wire [DATA_W-1:0] rdata_cap;

  always @* begin
    case (compat_mode)
      `FRS_MODE_SECOND: begin
        din_value = din_second(dsk_bit, rate_word);
      end
      `FRS_MODE_THIRD: begin
        din_value = din_third(dsk_bit, xfer_en_bit, precomp_off_r,
                              rate_word);
      end
      default: begin
        din_value = din_base(dsk_bit);
      end
    endcase
  end

  // Read data holds between reads, so the host may sample it late.
  always @* begin
    rdata_nxt = rdata_cap;
    if (din_rd) begin
      rdata_nxt = din_value;
    end
  end

  // Eight matching flops hold the read word.
  generate
    for (g = 0; g < DATA_W; g = g + 1) begin : g_rd
      reg bit_r;

      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          bit_r <= 1'b0;
        end else begin
          bit_r <= rdata_nxt[g];
        end
      end

      assign rdata_cap[g] = bit_r;
    end
  endgenerate

  always @* begin
    io_rdata = rdata_cap;
  end

  // ****************************************
  // Status byte 0
  // ****************************************
  wire [ST0_W-1:0] status_src;
  wire [ST0_W-1:0] status_cap;

  assign status_src = status_word(termination_code, seek_end, equipment_check, head_addr,
                                  drive_number);

  // One capture flop per bit; each holds until the next result phase loads it.
  generate
    for (g = 0; g < ST0_W; g = g + 1) begin : g_st0
      reg bit_r;

      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          bit_r <= 1'b0;
        end else if (result_load) begin
          bit_r <= status_src[g];
        end
      end

      assign status_cap[g] = bit_r;
    end
  endgenerate

  always @* begin
    status0 = status_cap;
  end

endmodule
`default_nettype wire

/* frs_defs.vh */
// Constants for the floppy rate-select and status register block.
// How it works
// - Input register bit 7 returns inverted disk-change pin, or the shadow value.
// - Second mode bit 0 low at 500K/1M, high at 250K/300K.
// - Rate bits survive software reset; hardware reset restores the 250K code.
// - Second mode input register bits 6..3 read as ones.
// - Third mode input register bits 6..4 read as zeros.
// - Third mode bit 2 mirrors last written precompensation-off bit.
// - Third mode bit 3 mirrors transfer-engine enable from output register bit 3.
// - Config control register is write-only at offset 0x07; rate resets to 10.
// - Third mode precomp-off bit stored, no effect, readable, survives software reset.
// - Density pin goes high on hardware reset; other resets leave it alone.
// - Result phase presents status bytes of the finished command.
// - Status byte 0 bits 7,6 encode termination cause 00/01/10/11.
// - Status byte 0 bit 5 set when seek, relative seek or recalibrate ends.
// - Status byte 0 bit 4 set on track-zero failure or outward overstep.
// - Status byte 0 bit 3 always zero.
// - Status byte 0 bit 2 is head, bits 1,0 the drive number.
// - Input register is read-only at 0x07, sharing the address with config control.
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH
`define FRS_OFS_CFG_DIN 3'h7
`define FRS_RATE_RST 2'h2
`define FRS_RATE_500K 2'h0
`define FRS_RATE_300K 2'h1
`define FRS_RATE_250K 2'h2
`define FRS_RATE_1M 2'h3
`define FRS_MODE_BASE 2'h0
`define FRS_MODE_SECOND 2'h1
`define FRS_MODE_THIRD 2'h2
`define FRS_BIT_PRECOMP 2
`define FRS_BIT_XFER_EN 3
`define FRS_TC_NORMAL 2'h0
`define FRS_TC_ABNORMAL 2'h1
`define FRS_TC_INVALID 2'h2
`define FRS_TC_POLLING 2'h3
`endif

/* frs_props.sv */
// Checker for the rate-select and status register block.
`timescale 1ns/100ps
`default_nettype none
module frs_props(input wire clock, sys_rst, soft_rst, io_wr, io_rd, disk_changed, shadow_sel,
  input wire shadow_disk_changed, result_load, seek_end, equipment_check, head_addr,
  input wire [2:0] io_addr, input wire [7:0] io_wdata, io_rdata, digital_output_reg, status0,
  input wire [1:0] compat_mode, data_rate, termination_code, drive_number,
  input wire density_select_pin);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire rd7 = io_rd && io_addr == 3'h7;
  wire wr7 = io_wr && io_addr == 3'h7;
  sequence s_chg; $changed(data_rate); endsequence
  property p_dens; s_chg |=> density_select_pin == ~^$past(data_rate); endproperty
  property p_wr; wr7 |=> data_rate == $past(io_wdata[1:0]); endproperty
  property p_keep; !wr7 |=> $stable(data_rate); endproperty
  property p_hold; !rd7 |=> $stable(io_rdata); endproperty
  property p_dsk; rd7 |=> io_rdata[7] == $past(shadow_sel ? shadow_disk_changed : !disk_changed);
  endproperty
  property p_m2; rd7 && compat_mode == 2'h1 |=> io_rdata[6:0] == {4'hF, $past(data_rate),
    ^$past(data_rate)}; endproperty
  property p_m3; rd7 && compat_mode == 2'h2 |=> io_rdata[6:3] == {3'h0,
    $past(digital_output_reg[3])} && io_rdata[1:0] == $past(data_rate); endproperty
  property p_st; result_load |=> status0 == {$past(termination_code), $past(seek_end),
    $past(equipment_check), 1'b0, $past(head_addr), $past(drive_number)}; endproperty
  a_dens: assert property (p_dens) else $error("density");
  a_wr: assert property (p_wr) else $error("rate write");
  a_keep: assert property (p_keep) else $error("rate kept");
  a_hold: assert property (p_hold) else $error("read hold");
  a_dsk: assert property (p_dsk) else $error("disk change");
  a_m2: assert property (p_m2) else $error("second mode");
  a_m3: assert property (p_m3) else $error("third mode");
  a_st: assert property (p_st) else $error("status byte");
endmodule
bind frs_regs frs_props u_frs_props(.*);
`default_nettype wire

/* frs_host.sv */
// Host model issuing port reads and writes.
`timescale 1ns/100ps
`default_nettype none
module frs_host(input wire clock, output logic [2:0] io_addr, output logic io_wr, io_rd,
  output logic [7:0] io_wdata);
  initial {io_addr, io_wr, io_rd, io_wdata} = 13'h0;
  // Strobes last one cycle, so every access is taken at exactly one edge.
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [1:0] m);
    @(posedge clock) #1 {io_wr, io_rd, io_addr} = {w, !w, a};
    io_wdata = d & (m == 2'h2 ? 8'h07 : 8'h03);
    @(posedge clock) #1 {io_wr, io_rd} = 2'h0;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the rate-select and status register block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 0, sys_rst = 1, soft_rst = 0, disk_changed = 1, shadow_sel = 0, result_load = 0;
  logic shadow_disk_changed = 0, seek_end = 0, equipment_check = 0, head_addr = 0;
  logic [7:0] digital_output_reg = 0;
  logic [1:0] compat_mode = 0, termination_code = 0, drive_number = 0;
  logic [6:0] v;
  wire [2:0] io_addr;
  wire io_wr, io_rd, density_select_pin;
  wire [7:0] io_wdata, io_rdata, status0;
  wire [1:0] data_rate;
  int err_count = 0, checked = 0;
  logic [19:0] rows [8] = '{20'h10078, 20'h1017B, 20'h1027D, 20'h1037E,
    20'h20707, 20'h20101, 20'h20404, 20'h00300};
  frs_regs u_frs_regs(.*);
  frs_host u_frs_host(.*);
  task chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  initial begin
    #100000 err_count++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 chk("rate", 8'h2, data_rate);
    chk("dens", 8'h1, density_select_pin);
    sys_rst = 0;
    foreach (rows[i]) begin
      compat_mode = rows[i][17:16];
      u_frs_host.acc(1, 3'h7, rows[i][15:8], compat_mode);
      u_frs_host.acc(0, 3'h7, 8'h0, compat_mode);
      chk("dir", rows[i][7:0], io_rdata);
      chk("dens", ~^rows[i][9:8], density_select_pin);
    end
    // Shadow wins over the pin, so the two choices must give different bits.
    {soft_rst, digital_output_reg, disk_changed, shadow_sel, compat_mode} = {9'h108, 4'h6};
    u_frs_host.acc(0, 3'h7, 8'h0, compat_mode);
    chk("soft", 8'h0F, io_rdata);
    u_frs_host.acc(1, 3'h5, 8'h02, compat_mode);
    chk("unmapped", 8'h3, data_rate);
    for (int k = 0; k < 4; k++) begin
      v = {k[1:0], k[0], ~k[0], k[1], ~k[1:0]};
      {termination_code, seek_end, equipment_check, head_addr, drive_number} = v;
      result_load = 1;
      @(posedge clock) #1 result_load = 0;
      chk("st0", {v[6:3], 1'b0, v[2:0]}, status0);
      @(posedge clock) #1;
    end
    {sys_rst, soft_rst, shadow_sel, digital_output_reg} = 11'h400;
    @(posedge clock) #1 sys_rst = 0;
    u_frs_host.acc(0, 3'h7, 8'h0, compat_mode);
    // Pin now low, so bit 7 reads high; precomp bit cleared, rate back to the 250K code.
    chk("hwrst", 8'h82, io_rdata);
    chk("dens", 8'h0, density_select_pin);
    summarize;
  end
endmodule
`default_nettype wire
